// ### pkg/bwp_regs.svh
// Offsets, field positions, reset values and key patterns of the gate
`ifndef BWP_REGS_SVH
`define BWP_REGS_SVH

`define BWP_KEY_OFS 8'h00
`define BWP_PROT_OFS 8'h04

`define BWP_MODE_LSB 0
`define BWP_MODE_MSB 1
`define BWP_LOCK_BIT 2
`define BWP_PASS_LSB 3
`define BWP_PASS_MSB 7

`define BWP_KEY_RST 8'h07
`define BWP_MODE_RST 2'h3
`define BWP_MODE_OFF 2'h0
`define BWP_LOCK_RST 1'h1
`define BWP_PROT_RST 8'h00

`define BWP_PASS_MODE 5'h18
`define BWP_PASS_OPEN 5'h13
`define BWP_PASS_CLOSE 5'h15

`endif

// ### pkg/bwp_pkg.sv
// Types shared by the bit write-protection gate
`default_nettype none
package bwp_pkg;

  typedef enum logic [1:0]
  {
    BWP_CMD_NONE = 2'h0,
    BWP_CMD_MODE = 2'h1,
    BWP_CMD_OPEN = 2'h3,
    BWP_CMD_CLOSE = 2'h2
  } bwp_cmd_e;

  typedef logic [1:0] bwp_mode_t;
  typedef logic [4:0] bwp_pass_t;

endpackage : bwp_pkg
`default_nettype wire

// ### hdl/bwp_key_dec.sv
// Decoder of the five-bit key field into a protection command
`timescale 1ns/10ps
`default_nettype none
`include "bwp_regs.svh"

module bwp_key_dec
(
  input wire bwp_pkg::bwp_pass_t pass,
  output var bwp_pkg::bwp_cmd_e cmd
);
  import bwp_pkg::*;

  always_comb
  begin
    unique case (pass)
      `BWP_PASS_MODE: cmd = BWP_CMD_MODE;
      `BWP_PASS_OPEN: cmd = BWP_CMD_OPEN;
      `BWP_PASS_CLOSE: cmd = BWP_CMD_CLOSE;
      default: cmd = BWP_CMD_NONE;
    endcase
  end

endmodule : bwp_key_dec
`default_nettype wire

// ### hdl/bwp_key.sv
// Bit write-protection key register with an AHB-Lite slave port
// Operation
// R1 - Mode 00: protected bits directly writable
// R2 - Any nonzero mode enforces the key scheme
// R3 - Mode changes only with key 11000
// R4 - Flag bit 2 reads 0 when writable
// R5 - Flag 1 blocks all protected writes
// R6 - Key 10011 opens access, clears flag
// R7 - Key 10101 closes access, sets flag
// R8 - Other key values change nothing
// R9 - Mode [1:0], flag 2, key [7:3]
// R10 - Open holds until close; reset locks (a mode key write with a nonzero mode also locks)
// R11 - Disabled scheme reads flag as 0
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "bwp_regs.svh"

module bwp_key
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic protOpen,
  output logic [7:0] protData
);
  import bwp_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  if (ADDR_W < 3)
  begin : g_chk
    $error("bwp_key: ADDR_W must be at least 3");
  end

  localparam logic [ADDR_W-1:0] KEY_ADDR = ADDR_W'(`BWP_KEY_OFS);
  localparam logic [ADDR_W-1:0] PROT_ADDR = ADDR_W'(`BWP_PROT_OFS);

  logic accept;
  logic wrPend_r;
  logic wrPend_nxt;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [ADDR_W-1:0] wrAddr_nxt;
  logic keyWr;
  logic protWr;
  logic [7:0] wrByte;
  bwp_cmd_e cmd;
  bwp_mode_t mode_r;
  bwp_mode_t mode_nxt;
  logic flag_r;
  logic flag_nxt;
  logic schemeOn;
  logic [7:0] protData_r;
  logic [7:0] protData_nxt;
  logic protOpen_r;
  logic protOpen_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  logic hresp_r;

  // Bus address phase
  always_comb
  begin
    accept = hsel && htrans[1] && hready;
    wrPend_nxt = accept && hwrite;
    wrAddr_nxt = accept ? haddr : wrAddr_r;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPend_r <= 1'h0;
      wrAddr_r <= '0;
    end
    else
    begin
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
    end
  end

  assign wrByte = hwdata[7:0];
  assign keyWr = wrPend_r && (wrAddr_r == KEY_ADDR);
  assign protWr = wrPend_r && (wrAddr_r == PROT_ADDR);
  assign schemeOn = (mode_r != `BWP_MODE_OFF); // R2

  bwp_key_dec u_dec
  (
    .pass(wrByte[`BWP_PASS_MSB:`BWP_PASS_LSB]),
    .cmd(cmd)
  );

  // Protection state
  always_comb
  begin
    mode_nxt = mode_r;
    flag_nxt = flag_r;
    if (keyWr)
    begin
      unique case (cmd)
        BWP_CMD_MODE:
        begin
          mode_nxt = wrByte[`BWP_MODE_MSB:`BWP_MODE_LSB]; // R3
          // Re-enabling starts locked; disabling reads open
          flag_nxt = (mode_nxt != `BWP_MODE_OFF); // R11
        end
        BWP_CMD_OPEN:
        begin
          if (schemeOn)
          begin
            flag_nxt = 1'h0; // R6
          end
        end
        BWP_CMD_CLOSE:
        begin
          if (schemeOn)
          begin
            flag_nxt = 1'h1; // R7
          end
        end
        BWP_CMD_NONE: flag_nxt = flag_r; // R8
      endcase
    end
    protOpen_nxt = !flag_nxt; // R4
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_r <= `BWP_MODE_RST; // R10
      flag_r <= `BWP_LOCK_RST; // R10
      protOpen_r <= 1'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      flag_r <= flag_nxt;
      protOpen_r <= protOpen_nxt;
    end
  end

  // Protected bits, guarded by the lock flag
  always_comb
  begin
    protData_nxt = protData_r;
    if (protWr && !flag_r) // R1 R5
    begin
      protData_nxt = wrByte;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      protData_r <= `BWP_PROT_RST;
    end
    else
    begin
      protData_r <= protData_nxt;
    end
  end

  // Read data from next values so a write just ahead is seen
  always_comb
  begin
    hrdata_nxt = 32'h0000_0000;
    if (accept && !hwrite)
    begin
      if (haddr == KEY_ADDR)
      begin
        hrdata_nxt[`BWP_MODE_MSB:`BWP_MODE_LSB] = mode_nxt; // R9
        hrdata_nxt[`BWP_LOCK_BIT] = flag_nxt; // R9
      end
      else if (haddr == PROT_ADDR)
      begin
        hrdata_nxt[7:0] = protData_nxt;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'h1;
      hresp_r <= 1'h0;
    end
    else
    begin
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= 1'h1;
      hresp_r <= 1'h0;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign protOpen = protOpen_r;
  assign protData = protData_r;

  property p_disabled_open;
    (mode_r == `BWP_MODE_OFF) |-> (!flag_r && protOpen_r);
  endproperty
  a_disabled_open: assert property (p_disabled_open) // R11
    else $error("flag set while scheme disabled");

  property p_enabled_gate;
    (keyWr && cmd == BWP_CMD_MODE && wrByte[1:0] != `BWP_MODE_OFF) |=> flag_r;
  endproperty
  a_enabled_gate: assert property (p_enabled_gate) // R2
    else $error("enabling mode left protected bits open");

  property p_prot_write;
    (protWr && !flag_r) |=> (protData_r == $past(wrByte));
  endproperty
  a_prot_write: assert property (p_prot_write) // R1
    else $error("open protected write lost");

  property p_prot_block;
    (protWr && flag_r) |=> $stable(protData_r);
  endproperty
  a_prot_block: assert property (p_prot_block) // R5
    else $error("locked protected write took effect");

  property p_mode_direct;
    (keyWr && cmd != BWP_CMD_MODE) |=> $stable(mode_r);
  endproperty
  a_mode_direct: assert property (p_mode_direct) // R3
    else $error("mode changed without mode key");

  property p_mode_key;
    (keyWr && cmd == BWP_CMD_MODE) |=>
      (mode_r == $past(wrByte[1:0]));
  endproperty
  a_mode_key: assert property (p_mode_key) // R3
    else $error("mode key did not load mode");

  property p_open;
    (keyWr && cmd == BWP_CMD_OPEN && schemeOn) |=>
      (!flag_r && protOpen_r);
  endproperty
  a_open: assert property (p_open) // R6
    else $error("open key did not clear flag");

  property p_close;
    (keyWr && cmd == BWP_CMD_CLOSE && schemeOn) |=>
      (flag_r && !protOpen_r);
  endproperty
  a_close: assert property (p_close) // R7
    else $error("close key did not set flag");

  property p_other_key;
    (keyWr && cmd == BWP_CMD_NONE) |=>
      ($stable(flag_r) && $stable(mode_r));
  endproperty
  a_other_key: assert property (p_other_key) // R8
    else $error("unknown key changed state");

  property p_hold;
    !keyWr |=> $stable(flag_r);
  endproperty
  a_hold: assert property (p_hold) // R10
    else $error("flag changed without key write");

  property p_readback;
    (accept && !hwrite && haddr == KEY_ADDR && !keyWr) |=>
      (hrdata_r[7:0] == {5'h00, flag_r, mode_r});
  endproperty
  a_readback: assert property (p_readback) // R9
    else $error("key register read wrong");

  property p_flag_zero;
    (protOpen_r && accept && !hwrite && haddr == KEY_ADDR) |->
      ##1 (hrdata_r[`BWP_LOCK_BIT] == flag_r);
  endproperty
  a_flag_zero: assert property (p_flag_zero) // R4
    else $error("read flag mismatches state");

endmodule : bwp_key
`default_nettype wire

// ### dv/bwp_key_tb.sv
// Self-checking bench for the bit write-protection key register
`timescale 1ns/10ps
`default_nettype none
`include "bwp_regs.svh"

module bwp_key_tb;
  import bwp_pkg::*;

  logic clk = 1'h0;
  logic sysRst = 1'h1;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic protOpen;
  wire logic [7:0] protData;
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  bwp_key #(.ADDR_W(8)) i_dut
  (
    .clk(clk),
    .sys_rst(sysRst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .protOpen(protOpen),
    .protData(protData)
  );

  task printVerdict;
    $display("Checks %0d, mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : printVerdict

  task check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Advance one edge, then on until hready is seen high
  task waitReady;
    @(posedge clk);
    while (hreadyout !== 1'h1)
      @(posedge clk);
  endtask : waitReady

  task busWrite(input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'h1;
    waitReady();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    waitReady();
  endtask : busWrite

  task busRead(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'h0;
    waitReady();
    htrans <= 2'h0;
    waitReady();
    check(hrdata, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : busRead

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      printVerdict();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    sysRst <= 1'h0;
    @(posedge clk);
    busRead(`BWP_KEY_OFS, 32'h07);
    check({31'h0, protOpen}, 32'h0);
    busRead(`BWP_PROT_OFS, 32'h00);
    busRead(8'h08, 32'h00);
    busWrite(`BWP_PROT_OFS, 8'hA5);
    busRead(`BWP_PROT_OFS, 32'h00);
    for (int k = 0; k < 32; k++)
      if (k != 5'h18 && k != 5'h13 && k != 5'h15)
      begin
        busWrite(`BWP_KEY_OFS, {k[4:0], 3'h0});
        busRead(`BWP_KEY_OFS, 32'h07);
      end
    $display("Reset and locked test done");
    busWrite(`BWP_KEY_OFS, {`BWP_PASS_OPEN, 3'h3});
    busRead(`BWP_KEY_OFS, 32'h03);
    check({31'h0, protOpen}, 32'h1);
    busWrite(`BWP_PROT_OFS, 8'h5A);
    busRead(`BWP_PROT_OFS, 32'h5A);
    check({24'h0, protData}, 32'h5A);
    busWrite(`BWP_KEY_OFS, 8'h00);
    busRead(`BWP_KEY_OFS, 32'h03);
    busWrite(`BWP_KEY_OFS, {`BWP_PASS_CLOSE, 3'h0});
    busRead(`BWP_KEY_OFS, 32'h07);
    check({31'h0, protOpen}, 32'h0);
    busWrite(`BWP_PROT_OFS, 8'h11);
    busRead(`BWP_PROT_OFS, 32'h5A);
    check({24'h0, protData}, 32'h5A);
    $display("Open and close test done");
    busWrite(`BWP_KEY_OFS, {`BWP_PASS_MODE, 3'h0});
    busRead(`BWP_KEY_OFS, 32'h00);
    check({31'h0, protOpen}, 32'h1);
    busWrite(`BWP_PROT_OFS, 8'h3C);
    busRead(`BWP_PROT_OFS, 32'h3C);
    check({24'h0, protData}, 32'h3C);
    busWrite(`BWP_KEY_OFS, {`BWP_PASS_CLOSE, 3'h0});
    busRead(`BWP_KEY_OFS, 32'h00);
    busWrite(`BWP_KEY_OFS, {`BWP_PASS_MODE, 3'h1});
    busRead(`BWP_KEY_OFS, 32'h05);
    busWrite(`BWP_PROT_OFS, 8'h77);
    busRead(`BWP_PROT_OFS, 32'h3C);
    check({24'h0, protData}, 32'h3C);
    $display("Mode change test done");
    busWrite(`BWP_KEY_OFS, {`BWP_PASS_OPEN, 3'h0});
    busRead(`BWP_KEY_OFS, 32'h01);
    hsel <= 1'h0;
    sysRst <= 1'h1;
    repeat (3) @(posedge clk);
    sysRst <= 1'h0;
    @(posedge clk);
    busRead(`BWP_KEY_OFS, 32'h07);
    busRead(`BWP_PROT_OFS, 32'h00);
    check({31'h0, protOpen}, 32'h0);
    check({24'h0, protData}, 32'h00);
    $display("Mid-run reset test done");
    printVerdict();
  end
endmodule : bwp_key_tb
`default_nettype wire
